// File: pkg/tcb_pkg.sv
// Purpose: Shared constants for the timer control-B clear/set path.
// Assumes: APB slave, 32-bit data, byte addresses.
// Notes: Offsets and fields of control B and its aliases.
package tcb_pkg;
	localparam logic [7:0] TCB_ADDR_CLR = 8'h04;
	localparam logic [7:0] TCB_ADDR_SET = 8'h08;
	localparam logic [7:0] TCB_ADDR_STATUS = 8'h0c;
	localparam logic [7:0] TCB_CTRLB_RESET = 8'h00;
	localparam int TCB_CMD_LSB = 5;
	localparam int TCB_CMD_MSB = 7;
	localparam int TCB_IDX_LSB = 3;
	localparam int TCB_IDX_MSB = 4;
	localparam int TCB_SINGLE_RUN_BIT_BIT = 2;
	localparam int TCB_LOCK_BIT = 1;
	localparam int TCB_DIR_BIT = 0;
	localparam logic [2:0] TCB_CMD_NONE = 3'h0;
	localparam logic [2:0] TCB_CMD_RETRIGGER = 3'h1;
	localparam logic [2:0] TCB_CMD_STOP = 3'h2;
	localparam logic [2:0] TCB_CMD_UPDATE = 3'h3;
	localparam logic [2:0] TCB_CMD_READ_SYNC = 3'h4;
	localparam logic [2:0] TCB_CMD_DMA = 3'h5;
	localparam logic [1:0] TCB_IDX_TOGGLE = 2'h0;
	localparam logic [1:0] TCB_IDX_FORCE_B = 2'h1;
	localparam logic [1:0] TCB_IDX_FORCE_A = 2'h2;
	localparam logic [1:0] TCB_IDX_HOLD = 2'h3;
	localparam logic [15:0] TCB_PRESC_RESET = 16'h0003;
	localparam logic [15:0] TCB_PERIOD_RESET = 16'h00ff;
endpackage

// File: hdl/tcb_ctrl.sv
// Purpose: Control-B command, ramp index and one-shot path of a timer.
// Assumes: APB slave; prescaled tick made by an internal prescaler.
// Notes: Clear alias writes ones to clear, set alias writes ones to set, one shared image.
// Contract
// - Clear alias clears control bits without read-modify-write; set alias shows the same state.
// - Command 1 retriggers, 2 stops, 3 forces a buffer update, 0 does nothing.
// - Command 4 forces a count read sync and command 5 issues one DMA trigger.
// - A written command runs on the next prescaled timer tick.
// - An executed command reads back as zero.
// - Clear alias: zeros to the command field do nothing, any one cancels the pending command.
// - Ramp index command forces cycle A/B changes in the dual-slope modes.
// - Ramp index 0 toggles, 1 forces B, 2 forces A, 3 holds the current cycle.
// - Pending ramp index command runs at the update condition, toggles, sets, clears or holds the flag and clears itself.
// - Clear alias: zeros to the ramp index field do nothing, any one cancels it.
// - With one-shot set, the counter stops at the next wrap or on a stop command.
// - Writing zero to one-shot through the clear alias leaves it unchanged.
`timescale 1ns/1ps
module tcb_ctrl
	import tcb_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	input wire logic clk_i, // 40 MHz clock
	input wire logic nrst_i, // Sync reset, active low
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB write
	input wire logic [7:0] paddr_i, // APB byte address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error
	input wire logic dual_ramp_mode_i, // Dual-slope ramp mode active
	input wire logic [15:0] presc_i, // Prescaler reload (ticks every presc+1)
	input wire logic [CNT_W-1:0] period_i, // Counter top
	output logic running_o, // Counter running
	output logic [CNT_W-1:0] count_o, // Counter value
	output logic ramp_index_flag_o, // Current ramp cycle, 1 = B
	output logic buffer_update_o, // Buffered registers copied (pulse)
	output logic read_sync_o, // Count read sync done (pulse)
	output logic single_dma_trigger_o // DMA trigger (pulse)
);
	logic [7:0] ctrlb_r;
	logic [15:0] presc_cnt_r;
	logic tick_r;
	logic [CNT_W-1:0] count_r;
	logic running_r;
	logic idx_r;
	logic [31:0] rdata_r;
	logic ready_r;
	logic err_r;
	logic upd_r;
	logic rsync_r;
	logic dma_r;
	logic wr_acc;
	logic wr_clr;
	logic wr_set;
	logic [7:0] wbyte;
	logic [2:0] cmd;
	logic [1:0] ramp_index_command;
	logic wrap;
	logic map_hit;

	// Write lands on the edge where the master sees pready high
	assign wr_acc = psel_i && penable_i && pwrite_i && ready_r;
	assign wr_clr = wr_acc && (paddr_i == TCB_ADDR_CLR);
	assign wr_set = wr_acc && (paddr_i == TCB_ADDR_SET);
	assign wbyte = pwdata_i[7:0];
	assign cmd = ctrlb_r[TCB_CMD_MSB:TCB_CMD_LSB];
	assign ramp_index_command = ctrlb_r[TCB_IDX_MSB:TCB_IDX_LSB];
	assign map_hit = (paddr_i == TCB_ADDR_CLR) || (paddr_i == TCB_ADDR_SET)
		|| (paddr_i == TCB_ADDR_STATUS);
	// Up-count wrap is the update condition
	assign wrap = tick_r && running_r && (count_r == period_i);

	// Prescaler making the timer tick
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			presc_cnt_r <= TCB_PRESC_RESET;
			tick_r <= 1'b0;
		end
		else if (presc_cnt_r == 16'h0000)
		begin
			presc_cnt_r <= presc_i;
			tick_r <= 1'b1;
		end
		else
		begin
			presc_cnt_r <= presc_cnt_r - 16'h0001;
			tick_r <= 1'b0;
		end
	end

	// Control B, one image behind both aliases
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			ctrlb_r <= TCB_CTRLB_RESET;
		else
		begin
			if (wr_clr)
			begin
				ctrlb_r[TCB_DIR_BIT] <= ctrlb_r[TCB_DIR_BIT] & ~wbyte[TCB_DIR_BIT];
				ctrlb_r[TCB_LOCK_BIT] <= ctrlb_r[TCB_LOCK_BIT] & ~wbyte[TCB_LOCK_BIT];
				ctrlb_r[TCB_SINGLE_RUN_BIT_BIT] <= ctrlb_r[TCB_SINGLE_RUN_BIT_BIT]
					& ~wbyte[TCB_SINGLE_RUN_BIT_BIT];
				if (wbyte[TCB_CMD_MSB:TCB_CMD_LSB] != TCB_CMD_NONE)
					ctrlb_r[TCB_CMD_MSB:TCB_CMD_LSB] <= TCB_CMD_NONE;
				else if (tick_r)
					ctrlb_r[TCB_CMD_MSB:TCB_CMD_LSB] <= TCB_CMD_NONE;
				if (wbyte[TCB_IDX_MSB:TCB_IDX_LSB] != TCB_IDX_TOGGLE)
					ctrlb_r[TCB_IDX_MSB:TCB_IDX_LSB] <= TCB_IDX_TOGGLE;
				else if (wrap)
					ctrlb_r[TCB_IDX_MSB:TCB_IDX_LSB] <= TCB_IDX_TOGGLE;
			end
			else if (wr_set)
			begin
				ctrlb_r[2:0] <= ctrlb_r[2:0] | wbyte[2:0];
				if (wbyte[TCB_CMD_MSB:TCB_CMD_LSB] != TCB_CMD_NONE)
					ctrlb_r[TCB_CMD_MSB:TCB_CMD_LSB] <= wbyte[TCB_CMD_MSB:TCB_CMD_LSB];
				else if (tick_r)
					ctrlb_r[TCB_CMD_MSB:TCB_CMD_LSB] <= TCB_CMD_NONE;
				if (wbyte[TCB_IDX_MSB:TCB_IDX_LSB] != TCB_IDX_TOGGLE)
					ctrlb_r[TCB_IDX_MSB:TCB_IDX_LSB] <= wbyte[TCB_IDX_MSB:TCB_IDX_LSB];
				else if (wrap)
					ctrlb_r[TCB_IDX_MSB:TCB_IDX_LSB] <= TCB_IDX_TOGGLE;
			end
			else
			begin
				if (tick_r)
					ctrlb_r[TCB_CMD_MSB:TCB_CMD_LSB] <= TCB_CMD_NONE;
				if (wrap)
					ctrlb_r[TCB_IDX_MSB:TCB_IDX_LSB] <= TCB_IDX_TOGGLE;
			end
		end
	end

	// Counter, run state and commands on the tick
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			count_r <= '0;
			running_r <= 1'b0;
		end
		else if (tick_r)
		begin
			if (cmd == TCB_CMD_RETRIGGER)
			begin
				count_r <= '0;
				running_r <= 1'b1;
			end
			else if (cmd == TCB_CMD_STOP)
				running_r <= 1'b0;
			else if (running_r)
			begin
				if (count_r == period_i)
				begin
					count_r <= '0;
					if (ctrlb_r[TCB_SINGLE_RUN_BIT_BIT])
						running_r <= 1'b0;
				end
				else
					count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Command pulses
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			upd_r <= 1'b0;
			rsync_r <= 1'b0;
			dma_r <= 1'b0;
		end
		else
		begin
			upd_r <= (tick_r && cmd == TCB_CMD_UPDATE)
				|| (wrap && !ctrlb_r[TCB_LOCK_BIT]);
			rsync_r <= tick_r && cmd == TCB_CMD_READ_SYNC;
			dma_r <= tick_r && cmd == TCB_CMD_DMA;
		end
	end

	// Ramp index flag, cycle B when set
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			idx_r <= 1'b0;
		else if (wrap && dual_ramp_mode_i)
		begin
			unique case (ramp_index_command)
				TCB_IDX_TOGGLE: idx_r <= ~idx_r;
				TCB_IDX_FORCE_B: idx_r <= 1'b1;
				TCB_IDX_FORCE_A: idx_r <= 1'b0;
				TCB_IDX_HOLD: idx_r <= idx_r;
			endcase
		end
	end

	// APB slave, one wait state
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			ready_r <= 1'b0;
			err_r <= 1'b0;
			rdata_r <= '0;
		end
		else if (psel_i && penable_i && !ready_r)
		begin
			ready_r <= 1'b1;
			err_r <= !map_hit;
			if (paddr_i == TCB_ADDR_CLR || paddr_i == TCB_ADDR_SET)
				rdata_r <= {24'h000000, ctrlb_r};
			else if (paddr_i == TCB_ADDR_STATUS)
				rdata_r <= {30'h0, running_r, idx_r};
			else
				rdata_r <= '0;
		end
		else
		begin
			ready_r <= 1'b0;
			err_r <= 1'b0;
		end
	end

	assign prdata_o = rdata_r;
	assign pready_o = ready_r;
	assign pslverr_o = err_r;
	assign running_o = running_r;
	assign count_o = count_r;
	assign ramp_index_flag_o = idx_r;
	assign buffer_update_o = upd_r;
	assign read_sync_o = rsync_r;
	assign single_dma_trigger_o = dma_r;
endmodule

// File: dv/tcb_chk.sv
// Purpose: Assertions on the control-B command path.
// Assumes: Latency checks only while presc_i is 3.
// Notes: Bound into tcb_ctrl.
`timescale 1ns/1ps
module tcb_chk
(
	input wire logic clk_i, // Clock
	input wire logic nrst_i, // Reset
	input wire logic psel_i, // Select
	input wire logic penable_i, // Enable
	input wire logic pwrite_i, // Write
	input wire logic pready_o, // Ready
	input wire logic [7:0] paddr_i, // Address
	input wire logic [31:0] pwdata_i, // Data
	input wire logic [15:0] presc_i, // Prescaler
	input wire logic running_o, // Running
	input wire logic ramp_index_flag_o, // Ramp flag
	input wire logic buffer_update_o, // Update
	input wire logic read_sync_o, // Sync
	input wire logic single_dma_trigger_o // DMA
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	wire logic [2:0] cmd = pwdata_i[7:5];
	wire logic go = psel_i & penable_i & pwrite_i & !pready_o
		& paddr_i == 8'h08 & presc_i == 16'h0003;
	dma_pulse_a: assert property (single_dma_trigger_o |=> !single_dma_trigger_o)
		else $error("dma pulse too long");
	sync_pulse_a: assert property (read_sync_o |=> !read_sync_o)
		else $error("sync pulse too long");
	dma_lat_a: assert property (go && cmd == 3'h5 |-> ##[1:6] single_dma_trigger_o)
		else $error("dma trigger late");
	sync_lat_a: assert property (go && cmd == 3'h4 |-> ##[1:6] read_sync_o)
		else $error("read sync late");
	upd_lat_a: assert property (go && cmd == 3'h3 |-> ##[1:6] buffer_update_o)
		else $error("update late");
	stop_lat_a: assert property (go && cmd == 3'h2 |-> ##[1:7] !running_o)
		else $error("stop late");
	run_lat_a: assert property (go && cmd == 3'h1 |-> ##[1:7] running_o)
		else $error("retrigger late");
	flag_wrap_a: assert property ($changed(ramp_index_flag_o) |-> $past(running_o))
		else $error("flag moved while stopped");
endmodule
bind tcb_ctrl tcb_chk chk_u (.*);

// File: dv/testbench.sv
// Purpose: Directed test of the control-B clear path.
// Assumes: Counter top 4, dual ramp mode on except during one ramp index check.
// Notes: Pulses counted in p[].
`timescale 1ns/1ps
module testbench;
	logic clk_i = '0, nrst_i = '0, psel_i = '0, penable_i = '0, pwrite_i = '0, er, f;
	logic [7:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0, prdata_o, rd;
	logic [15:0] presc_i = 16'h0003;
	logic dual_i = 1'b1;
	logic pready_o, pslverr_o, running_o, ramp_index_flag_o;
	logic buffer_update_o, read_sync_o, single_dma_trigger_o;
	logic [1:0] ix[5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h3};
	logic [7:0] wa[6] = '{8'h08, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04};
	logic [7:0] wd[6] = '{8'haf, 8'h00, 8'h20, 8'h10, 8'h04, 8'h03};
	logic [7:0] ex[6] = '{8'haf, 8'haf, 8'h0f, 8'h07, 8'h03, 8'h00};
	int n_fail = 0, num_checks = 0, cyc = 0, p[3];
	tcb_ctrl dut_u (.*, .count_o(), .period_i(16'h0004), .dual_ramp_mode_i(dual_i));
	always #12.5 clk_i = ~clk_i;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cyc++;
		p[0] += buffer_update_o;
		p[1] += read_sync_o;
		p[2] += single_dma_trigger_o;
		if (cyc == 20000)
		begin
			n_fail++;
			finish_test();
		end
	end
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= {24'h0, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic cmd(input logic [7:0] d, input logic e);
		xfer(1'b1, 8'h08, d);
		repeat (8) @(posedge clk_i);
		chk(running_o, e);
	endtask
	initial
	begin
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		xfer(1'b0, 8'h04, 8'h00);
		chk(rd, 0);
		xfer(1'b0, 8'h10, 8'h00);
		chk({er, rd}, {1'b1, 32'h0});
		$display("test reset done");
		for (int c = 3; c < 6; c++)
		begin
			p = '{0, 0, 0};
			xfer(1'b1, 8'h08, 8'(c << 5));
			repeat (8) @(posedge clk_i);
			chk(33'(p[c - 3]), 1);
			xfer(1'b0, 8'h08, 8'h00);
			chk(rd, 0);
		end
		$display("test pulses done");
		cmd(8'h20, 1'b1);
		cmd(8'h40, 1'b0);
		cmd(8'h24, 1'b1);
		repeat (60) @(posedge clk_i);
		chk(running_o, 0);
		xfer(1'b1, 8'h04, 8'h04);
		cmd(8'h20, 1'b1);
		repeat (60) @(posedge clk_i);
		chk(running_o, 1);
		$display("test run done");
		for (int i = 0; i < 5; i++)
		begin
			xfer(1'b1, 8'h08, {3'h0, ix[i], 3'h0});
			@(posedge clk_i);
			f = ramp_index_flag_o;
			do xfer(1'b0, 8'h08, 8'h00); while (rd[4:3] !== 2'h0);
			chk(ramp_index_flag_o, ix[i] == 2'h3 ? f : ix[i] == 2'h1);
		end
		dual_i <= 1'b0;
		f = ramp_index_flag_o;
		xfer(1'b1, 8'h08, 8'h10);
		do xfer(1'b0, 8'h08, 8'h00); while (rd[4:3] !== 2'h0);
		chk(ramp_index_flag_o, f);
		dual_i <= 1'b1;
		$display("test ramp done");
		cmd(8'h40, 1'b0);
		presc_i <= 16'h00ff;
		p = '{0, 0, 0};
		xfer(1'b1, 8'h08, 8'h80);
		while (p[1] == 0) @(posedge clk_i);
		for (int i = 0; i < 6; i++)
		begin
			xfer(1'b1, wa[i], wd[i]);
			xfer(1'b0, 8'h0c ^ wa[i], 8'h00);
			chk(rd, ex[i]);
		end
		repeat (300) @(posedge clk_i);
		chk(33'(p[2]), 0);
		$display("test clear done");
		finish_test();
	end
endmodule
